// ---- shared/acs_defs.svh ----
// Constants for the converter sequencer: register offsets, field positions,
// reset values and conversion tick counts.
// Assumes inclusion by bare name from any file that decodes these fields.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ACS_OFS_STATUS 3'h0
`define ACS_OFS_RESULT 3'h1
`define ACS_OFS_CLKCFG 3'h2
`define ACS_OFS_PDATA 3'h3
`define ACS_OFS_PDDR 3'h4

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define ACS_BIT_DONE 7
`define ACS_BIT_IEN 6
`define ACS_BIT_CONT 5
`define ACS_CHAN_PD 5'h1f
`define ACS_CHAN_PINS 5'h08
`define ACS_DIV_MAX 3'h4
`define ACS_PRE_MAX 4'hf
`define ACS_PRE_ONE 4'h1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ACS_RST_CHAN 5'h1f
`define ACS_RST_DIV 3'h0
`define ACS_RST_BYTE 8'h00

// ----------------------------------------------------------------------------
// Conversion timing in converter clock ticks
// ----------------------------------------------------------------------------
`define ACS_CNT_FIRST 4'h0
`define ACS_CNT_LAST 4'hf
`define ACS_CNT_ONE 4'h1
`define ACS_CODE_MSB 8'h80
`define ACS_BIT_MSB 3'h7
`define ACS_BIT_LSB 3'h0

`endif

// ---- shared/acs_pkg.sv ----
// Types shared by the converter sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package acs_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states, Gray coded along idle, sample, approximate, hold
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMP = 2'b01,
        ST_SAR = 2'b11,
        ST_HOLD = 2'b10
    } acs_state_t;

    // ------------------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic done_sel;
        logic irq_en;
        logic cont;
        logic [4:0] chan;
    } acs_ctrl_t;

    typedef struct packed {
        logic [2:0] div;
        logic src;
        logic [3:0] rsv;
    } acs_clkcfg_t;

endpackage : acs_pkg

// ---- verilog/acs_top.sv ----
// Sequencer and port takeover around an 8-bit successive approximation core.
// Assumes a comparator input and an external clock tick synchronous to MCLK,
// and port pins that arrive asynchronously.
//
// Behaviour
// - The selected channel pin is forced to be the converter input.
// - Every other pin stays under ordinary port control.
// - Port writes ignore the taken pin; its port read returns zero.
// - High reference codes ff, low reference codes 00, linear in between.
// - Every status/control write starts a new conversion, except one that writes the power-down channel code.
// - A conversion takes exactly 16 converter clock ticks.
// - Continuous mode repeats until cleared; otherwise one conversion per start.
// - Continuous mode overwrites the result after every conversion.
// - Continuous mode sets the done flag after the first conversion only.
// - Interrupts off: shared bit is a read-only done flag, cleared by access.
// - Interrupts on: shared bit selects DMA (1) or CPU (0) service.
// - Interrupts on: a request rises per conversion, cleared by access.
// - Reset clears interrupt enable, continuous mode and the shared bit.
// - A 5-bit channel field; codes zero to seven pick pins 0 to 7.
// - Unused channel codes may give an undefined result.
// - All channel bits set powers the converter down.
// - Conversions continue in wait mode; a CPU request can wake the CPU.
// - Stop mode aborts conversion; conversion resumes after stop exits.
// - One 8-bit result register updated at each conversion end.
// - Converter clock is the selected input divided by 1, 2, 4, 8 or 16.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"

module acs_top (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic XCLK_TICK,
    input wire logic COMP,
    input wire logic STOP_MODE,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PORT_OUT,
    output logic [7:0] PORT_OE,
    output logic [7:0] ANALOG_SEL,
    output logic [7:0] SAR_CODE,
    output logic SAMPLE,
    output logic POWER_DOWN,
    output logic CPU_IRQ,
    output logic DMA_IRQ
);
    import acs_pkg::*;

    // ------------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------------
    function automatic logic [7:0] onehot8(input logic [2:0] idx);
        onehot8 = 8'h01 << idx;
    endfunction : onehot8

    // Pins taken by the converter; unused and power-down codes take none.
    function automatic logic [7:0] taken_mask(input logic [4:0] chan);
        taken_mask = (chan < `ACS_CHAN_PINS) ? onehot8(chan[2:0]) : 8'h00;
    endfunction : taken_mask

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    acs_state_t state, next_state;
    acs_ctrl_t ctrl, next_ctrl;
    acs_clkcfg_t clkcfg, next_clkcfg;
    logic [7:0] result, next_result;
    logic [7:0] pdata, next_pdata;
    logic [7:0] pddr, next_pddr;
    logic [7:0] code, next_code;
    logic [2:0] sbit, next_sbit;
    logic [3:0] cnt, next_cnt;
    logic [3:0] pre, next_pre;
    logic first, next_first;
    logic irq, next_irq;
    logic aborted, next_aborted;
    logic stop_q, next_stop_q;
    logic [7:0] next_rdata;
    logic [7:0] pin_m, pin_s;

    logic wr_st, rd_res, start, tick, src_tick, conv_done;
    logic [3:0] ratio;
    logic [7:0] taken, next_taken, mask;

    // ------------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------------
    // The port pins change with no relation to MCLK, so they are resampled
    // twice before the read mux looks at them.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_m <= `ACS_RST_BYTE;
            pin_s <= `ACS_RST_BYTE;
        end else begin
            pin_m <= PIN_IN;
            pin_s <= pin_m;
        end
    end

    // ------------------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------------------
    always_comb begin
        src_tick = clkcfg.src | XCLK_TICK;
        if (clkcfg.div >= `ACS_DIV_MAX) begin
            ratio = `ACS_PRE_MAX;
        end else begin
            ratio = 4'((`ACS_PRE_ONE << clkcfg.div) - `ACS_PRE_ONE);
        end
        tick = (state != ST_IDLE) && src_tick && (pre == ratio);
        taken = taken_mask(ctrl.chan);
        mask = onehot8(sbit);
        conv_done = tick && (state == ST_HOLD) && (cnt == `ACS_CNT_LAST);
    end

    // ------------------------------------------------------------------------
    // Registers, sequencer and next values
    // ------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_clkcfg = clkcfg;
        next_result = result;
        next_pdata = pdata;
        next_pddr = pddr;
        next_code = code;
        next_sbit = sbit;
        next_cnt = cnt;
        next_pre = pre;
        next_first = first;
        next_irq = irq;
        next_aborted = aborted;
        next_stop_q = STOP_MODE;
        next_rdata = `ACS_RST_BYTE;
        wr_st = WR && (ADDR == `ACS_OFS_STATUS);
        rd_res = RD && (ADDR == `ACS_OFS_RESULT);
        start = 1'b0;

        // Bus writes.
        if (wr_st) begin
            next_ctrl.chan = WDATA[4:0];
            next_ctrl.cont = WDATA[`ACS_BIT_CONT];
            next_ctrl.irq_en = WDATA[`ACS_BIT_IEN];
            // The shared bit is only writable while interrupts are enabled.
            next_ctrl.done_sel = WDATA[`ACS_BIT_IEN] & WDATA[`ACS_BIT_DONE];
            next_first = 1'b0;
            next_irq = 1'b0;
            start = (WDATA[4:0] != `ACS_CHAN_PD);
        end
        if (WR && (ADDR == `ACS_OFS_CLKCFG)) begin
            next_clkcfg.div = WDATA[7:5];
            next_clkcfg.src = WDATA[4];
        end
        if (WR && (ADDR == `ACS_OFS_PDATA)) begin
            next_pdata = (WDATA & ~taken) | (pdata & taken);
        end
        if (WR && (ADDR == `ACS_OFS_PDDR)) begin
            next_pddr = (WDATA & ~taken) | (pddr & taken);
        end

        // Result read clears the flag, or the request when interrupts are on.
        if (rd_res) begin
            if (!ctrl.irq_en) begin
                next_ctrl.done_sel = 1'b0;
            end
            next_irq = 1'b0;
        end

        // Bus reads.
        if (RD) begin
            case (ADDR)
                `ACS_OFS_STATUS: next_rdata = ctrl;
                `ACS_OFS_RESULT: next_rdata = result;
                `ACS_OFS_CLKCFG: next_rdata = {clkcfg.div, clkcfg.src, 4'h0};
                `ACS_OFS_PDATA: next_rdata = ((pddr & pdata) | (~pddr & pin_s)) & ~taken;
                `ACS_OFS_PDDR: next_rdata = pddr;
                default: next_rdata = `ACS_RST_BYTE;
            endcase
        end

        // Prescaler runs only while a conversion is under way.
        if (state != ST_IDLE && src_tick) begin
            next_pre = (pre == ratio) ? `ACS_CNT_FIRST : 4'(pre + `ACS_PRE_ONE);
        end

        // Sequencer: one sample tick, eight approximation ticks, then hold
        // until the sixteenth tick.
        case (state)
            ST_IDLE: begin
                next_state = ST_IDLE;
            end
            ST_SAMP: begin
                if (tick) begin
                    next_state = ST_SAR;
                    next_cnt = 4'(cnt + `ACS_CNT_ONE);
                    next_code = `ACS_CODE_MSB;
                    next_sbit = `ACS_BIT_MSB;
                end
            end
            ST_SAR: begin
                if (tick) begin
                    // Comparator high means input at or above the trial code,
                    // so a full-scale input keeps every bit.
                    next_code = COMP ? code : (code & ~mask);
                    next_cnt = 4'(cnt + `ACS_CNT_ONE);
                    if (sbit == `ACS_BIT_LSB) begin
                        next_state = ST_HOLD;
                    end else begin
                        next_sbit = 3'(sbit - 3'h1);
                        next_code = (COMP ? code : (code & ~mask)) | onehot8(3'(sbit - 3'h1));
                    end
                end
            end
            ST_HOLD: begin
                if (tick) begin
                    next_cnt = 4'(cnt + `ACS_CNT_ONE);
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // Conversion end; placed after the clears so that the set wins.
        if (conv_done) begin
            next_result = code;
            next_first = 1'b1;
            if (!ctrl.irq_en && (!ctrl.cont || !first)) begin
                next_ctrl.done_sel = 1'b1;
            end
            if (ctrl.irq_en) begin
                next_irq = 1'b1;
            end
            next_cnt = `ACS_CNT_FIRST;
            next_state = ctrl.cont ? ST_SAMP : ST_IDLE;
        end

        // Stop mode aborts; the conversion restarts once stop is left.
        if (stop_q && !STOP_MODE && (aborted || ctrl.cont) && (ctrl.chan != `ACS_CHAN_PD)) begin
            start = 1'b1;
            next_aborted = 1'b0;
        end
        if (start) begin
            next_state = ST_SAMP;
            next_cnt = `ACS_CNT_FIRST;
            next_pre = 4'h0;
        end
        if (STOP_MODE) begin
            next_aborted = aborted || start || (state != ST_IDLE);
            next_state = ST_IDLE;
            next_cnt = `ACS_CNT_FIRST;
        end
        if (wr_st && (WDATA[4:0] == `ACS_CHAN_PD)) begin
            next_state = ST_IDLE;
            next_aborted = 1'b0;
        end
        next_taken = taken_mask(next_ctrl.chan);
    end

    // Registering only. Wait mode is not an input: the sequencer simply
    // keeps running, so a CPU request can wake the processor.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            ctrl <= {1'b0, 1'b0, 1'b0, `ACS_RST_CHAN};
            clkcfg <= {`ACS_RST_DIV, 1'b0, 4'h0};
            result <= `ACS_RST_BYTE;
            pdata <= `ACS_RST_BYTE;
            pddr <= `ACS_RST_BYTE;
            code <= `ACS_RST_BYTE;
            sbit <= `ACS_BIT_MSB;
            cnt <= `ACS_CNT_FIRST;
            pre <= 4'h0;
            first <= 1'b0;
            irq <= 1'b0;
            aborted <= 1'b0;
            stop_q <= 1'b0;
            RDATA <= `ACS_RST_BYTE;
            PORT_OUT <= `ACS_RST_BYTE;
            PORT_OE <= `ACS_RST_BYTE;
            ANALOG_SEL <= `ACS_RST_BYTE;
            SAR_CODE <= `ACS_RST_BYTE;
            SAMPLE <= 1'b0;
            POWER_DOWN <= 1'b1;
            CPU_IRQ <= 1'b0;
            DMA_IRQ <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            clkcfg <= next_clkcfg;
            result <= next_result;
            pdata <= next_pdata;
            pddr <= next_pddr;
            code <= next_code;
            sbit <= next_sbit;
            cnt <= next_cnt;
            pre <= next_pre;
            first <= next_first;
            irq <= next_irq;
            aborted <= next_aborted;
            stop_q <= next_stop_q;
            RDATA <= next_rdata;
            PORT_OUT <= next_pdata & ~next_taken;
            PORT_OE <= next_pddr & ~next_taken;
            // Unused codes select no pin, so the result is undefined.
            ANALOG_SEL <= next_taken;
            SAR_CODE <= next_code;
            SAMPLE <= (next_state == ST_SAMP);
            POWER_DOWN <= (next_ctrl.chan == `ACS_CHAN_PD);
            CPU_IRQ <= next_irq & ~next_ctrl.done_sel;
            DMA_IRQ <= next_irq & next_ctrl.done_sel;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic [4:0] ticks_seen;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ticks_seen <= 5'h00;
        end else if (next_state == ST_SAMP && (start || conv_done)) begin
            ticks_seen <= 5'h00;
        end else if (tick) begin
            ticks_seen <= 5'(ticks_seen + 5'h01);
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    AST_PIN_EXCLUSIVE: assert property ((ANALOG_SEL & PORT_OE) == 8'h00)
        else $error("taken pin is driven by the port");
    AST_PORT_READ_ZERO: assert property (RD && ADDR == `ACS_OFS_PDATA && ctrl.chan < `ACS_CHAN_PINS
        |=> RDATA[$past(ctrl.chan[2:0])] == 1'b0)
        else $error("taken pin read back nonzero");
    AST_WRITE_STARTS: assert property (wr_st && WDATA[4:0] != `ACS_CHAN_PD && !STOP_MODE
        |=> state == ST_SAMP && cnt == `ACS_CNT_FIRST)
        else $error("status write did not start a conversion");
    AST_SIXTEEN_TICKS: assert property (conv_done |-> ticks_seen == 5'h0f)
        else $error("conversion length is not sixteen ticks");
    AST_SINGLE_STOPS: assert property (conv_done && !ctrl.cont && !wr_st && !STOP_MODE
        |=> state == ST_IDLE ##1 state == ST_IDLE)
        else $error("single conversion did not stop");
    AST_RESULT_LOAD: assert property (conv_done |=> result == $past(code))
        else $error("result not loaded at conversion end");
    AST_FLAG_CLEAR: assert property (wr_st && !WDATA[`ACS_BIT_IEN] |=> !ctrl.done_sel)
        else $error("status write did not clear done flag");
    AST_IRQ_RAISE: assert property (conv_done && ctrl.irq_en && !wr_st
        |=> (CPU_IRQ ^ DMA_IRQ) && (DMA_IRQ == ctrl.done_sel))
        else $error("interrupt request missing or misrouted");
    AST_POWER_DOWN: assert property (ctrl.chan == `ACS_CHAN_PD |-> POWER_DOWN && state == ST_IDLE)
        else $error("power down code did not stop the converter");
    AST_STOP_ABORT: assert property (STOP_MODE |=> state == ST_IDLE)
        else $error("conversion runs in stop mode");

    COV_SINGLE: cover property (wr_st ##[1:300] conv_done);
    COV_CONT_TWICE: cover property (conv_done && ctrl.cont ##[1:300] conv_done);
    COV_DMA: cover property (DMA_IRQ);
    COV_STOP_RESUME: cover property (STOP_MODE && aborted ##1 !STOP_MODE ##1 state == ST_SAMP);

endmodule : acs_top
`default_nettype wire

// ---- test/acs_analog_model.sv ----
// Analog mux and comparator standing behind the converter sequencer.
// Assumes one analog level per channel and a registered trial code.
`timescale 1ns/1ps
`default_nettype none

module acs_analog_model (
    input wire logic mclk,
    input wire logic [63:0] vin_flat,
    input wire logic [7:0] analog_sel,
    input wire logic [7:0] sar_code,
    input wire logic power_down,
    output logic comp
);
    logic toggle = 1'b0;
    logic [7:0] vin;
    logic hit;

    // An open mux input floats, so the comparator is given a changing level.
    always @(posedge mclk) toggle <= ~toggle;

    always_comb begin
        vin = 8'h00;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (analog_sel[i]) begin
                vin = vin_flat[i*8 +: 8];
                hit = 1'b1;
            end
        end
        // Full scale codes ff, ground codes 00, straight line between.
        comp = (power_down || !hit) ? toggle : (vin >= sar_code);
    end
endmodule : acs_analog_model
`default_nettype wire

// ---- test/acs_top_test.sv ----
// Self-checking bench for the converter sequencer.
// Assumes the register indices and field positions of acs_defs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"

module acs_top_test;
    logic MCLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, XCLK_TICK = 1'b0, STOP_MODE = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00, PIN_IN = 8'h00;
    logic [7:0] RDATA, PORT_OUT, PORT_OE, ANALOG_SEL, SAR_CODE;
    logic SAMPLE, POWER_DOWN, CPU_IRQ, DMA_IRQ, COMP;
    logic [63:0] vin_flat = 64'h0;
    logic [7:0] d;
    int n_fail = 0, checked = 0, seed = 61235, r;

    always #12.5 MCLK = ~MCLK;
    always @(posedge MCLK) XCLK_TICK <= $random(seed);

    acs_top u_dut (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .XCLK_TICK(XCLK_TICK), .COMP(COMP), .STOP_MODE(STOP_MODE), .PIN_IN(PIN_IN),
        .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE), .ANALOG_SEL(ANALOG_SEL), .SAR_CODE(SAR_CODE),
        .SAMPLE(SAMPLE), .POWER_DOWN(POWER_DOWN), .CPU_IRQ(CPU_IRQ), .DMA_IRQ(DMA_IRQ));

    acs_analog_model u_ana (.mclk(MCLK), .vin_flat(vin_flat), .analog_sel(ANALOG_SEL),
        .sar_code(SAR_CODE), .power_down(POWER_DOWN), .comp(COMP));

    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr

    task rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask : rd

    task cyc(input int n);
        repeat (n) @(posedge MCLK);
    endtask : cyc

    // Bench model: the code expected for a channel is its analog level.
    function automatic logic [7:0] expv(input int ch);
        return vin_flat[ch*8 +: 8];
    endfunction : expv

    task print_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge MCLK);
        n_fail++;
        print_verdict;
    end

    initial begin
        for (int i = 0; i < 8; i++) vin_flat[i*8 +: 8] = $random(seed);
        vin_flat[7:0] = 8'hff;
        vin_flat[15:8] = 8'h00;
        cyc(16);
        RST_N <= 1'b1;
        rd(`ACS_OFS_STATUS, d); chk("status reset", d, 8'h1f);
        cyc(1);
        #1 chk("rdata idle", RDATA, 8'h00);
        chk("power down", {7'h0, POWER_DOWN}, 8'h01);
        rd(3'h7, d); chk("unmapped", d, 8'h00);
        rd(`ACS_OFS_CLKCFG, d); chk("clkcfg reset", d, 8'h00);
        wr(`ACS_OFS_CLKCFG, 8'h10);
        $display("test reset done");

        wr(`ACS_OFS_STATUS, 8'h00);
        cyc(20);
        for (int ch = 0; ch < 8; ch++) begin
            wr(`ACS_OFS_STATUS, 8'(ch));
            #1 chk("sample", {7'h0, SAMPLE}, 8'h01);
            cyc(2);
            chk("mux select", ANALOG_SEL, 8'h01 << ch);
            chk("powered", {7'h0, POWER_DOWN}, 8'h00);
            cyc(10);
            rd(`ACS_OFS_STATUS, d); chk("done early", d[7], 1'b0);
            cyc(3);
            rd(`ACS_OFS_STATUS, d); chk("done set", d, 8'h80 | 8'(ch));
            rd(`ACS_OFS_RESULT, d); chk("result", d, expv(ch));
            rd(`ACS_OFS_STATUS, d); chk("done cleared", d[7], 1'b0);
        end
        $display("test single done");

        for (int dv = 0; dv < 5; dv++) begin
            r = (dv >= 4) ? 16 : (1 << dv);
            wr(`ACS_OFS_CLKCFG, {3'(dv), 1'b1, 4'h0});
            wr(`ACS_OFS_STATUS, 8'h02);
            cyc(16 * r - 6);
            rd(`ACS_OFS_STATUS, d); chk("div early", d[7], 1'b0);
            cyc(6);
            rd(`ACS_OFS_STATUS, d); chk("div done", d[7], 1'b1);
            rd(`ACS_OFS_RESULT, d); chk("div result", d, expv(2));
        end
        wr(`ACS_OFS_CLKCFG, 8'h00);
        wr(`ACS_OFS_STATUS, 8'h02);
        cyc(120);
        rd(`ACS_OFS_STATUS, d); chk("ext tick done", d[7], 1'b1);
        rd(`ACS_OFS_RESULT, d); chk("ext tick result", d, expv(2));
        wr(`ACS_OFS_CLKCFG, 8'h10);
        $display("test divider done");

        PIN_IN <= $random(seed);
        wr(`ACS_OFS_PDATA, 8'hff);
        wr(`ACS_OFS_PDDR, 8'hff);
        wr(`ACS_OFS_STATUS, 8'h03);
        cyc(3);
        chk("port oe", PORT_OE, 8'hf3);
        chk("port out", PORT_OUT, 8'hf3);
        wr(`ACS_OFS_PDATA, 8'h00);
        wr(`ACS_OFS_PDDR, 8'h07);
        rd(`ACS_OFS_PDATA, d); chk("taken pin read", d, {PIN_IN[7:4], 4'h0});
        wr(`ACS_OFS_STATUS, 8'h0a);
        cyc(3);
        chk("unused code", ANALOG_SEL, 8'h00);
        wr(`ACS_OFS_STATUS, 8'h1f);
        cyc(3);
        rd(`ACS_OFS_PDATA, d); chk("pin released", d, {PIN_IN[7:4], 4'h8});
        chk("oe released", PORT_OE, 8'h0f);
        $display("test port done");

        wr(`ACS_OFS_STATUS, 8'h25);
        cyc(20);
        rd(`ACS_OFS_STATUS, d); chk("cont first", d[7], 1'b1);
        vin_flat[47:40] = $random(seed);
        cyc(30);
        rd(`ACS_OFS_STATUS, d); chk("cont flag held", d[7], 1'b1);
        rd(`ACS_OFS_RESULT, d); chk("cont overwrite", d, expv(5));
        vin_flat[47:40] = $random(seed);
        cyc(30);
        rd(`ACS_OFS_STATUS, d); chk("cont no reflag", d[7], 1'b0);
        rd(`ACS_OFS_RESULT, d); chk("cont repeat", d, expv(5));
        wr(`ACS_OFS_STATUS, 8'h05);
        cyc(20);
        d = expv(5);
        vin_flat[47:40] = ~d;
        cyc(40);
        rd(`ACS_OFS_RESULT, d); chk("single stops", d, ~vin_flat[47:40]);
        $display("test continuous done");

        wr(`ACS_OFS_STATUS, 8'h44);
        cyc(20);
        chk("cpu irq", {6'h0, CPU_IRQ, DMA_IRQ}, 8'h02);
        rd(`ACS_OFS_STATUS, d); chk("select cpu", d, 8'h44);
        rd(`ACS_OFS_RESULT, d);
        cyc(1);
        chk("cpu irq clear", {7'h0, CPU_IRQ}, 8'h00);
        wr(`ACS_OFS_STATUS, 8'hc4);
        cyc(20);
        chk("dma irq", {6'h0, CPU_IRQ, DMA_IRQ}, 8'h01);
        rd(`ACS_OFS_STATUS, d); chk("select dma", d, 8'hc4);
        wr(`ACS_OFS_STATUS, 8'h84);
        cyc(1);
        chk("dma clear by write", {7'h0, DMA_IRQ}, 8'h00);
        rd(`ACS_OFS_STATUS, d); chk("select ro", d[7], 1'b0);
        $display("test interrupt done");

        wr(`ACS_OFS_STATUS, 8'h06);
        cyc(5);
        STOP_MODE <= 1'b1;
        vin_flat[55:48] = $random(seed);
        cyc(30);
        rd(`ACS_OFS_STATUS, d); chk("stop aborts", d[7], 1'b0);
        STOP_MODE <= 1'b0;
        cyc(22);
        rd(`ACS_OFS_STATUS, d); chk("stop resume", d[7], 1'b1);
        rd(`ACS_OFS_RESULT, d); chk("stop result", d, expv(6));
        $display("test stop done");
        print_verdict;
    end
endmodule : acs_top_test
`default_nettype wire
